// >>> core/flrf_pkg.sv
// Purpose: shared constants for the fault log record formatter
// Assumes: byte numbers count from the first record byte after the block length
// Notes: adc step numbers of each quantity are local assignments of the mux schedule
package flrf_pkg;
   // record framing
   localparam logic [7:0] FLRF_REC_LEN = 8'h93;      // 147 bytes
   localparam logic [7:0] FLRF_LEN_NONE = 8'h00;     // no log captured
   localparam logic [7:0] FLRF_LAST_IDX = 8'h92;     // byte 146
   localparam logic [7:0] FLRF_RSVD_BYTE = 8'h00;
   // header byte numbers
   localparam logic [7:0] FLRF_B_TEXT = 8'h11;       // 17,18
   localparam logic [7:0] FLRF_B_RSV19 = 8'h13;
   localparam logic [7:0] FLRF_B_RSV20 = 8'h14;
   localparam logic [7:0] FLRF_B_TDIE = 8'h15;       // 21,22
   localparam logic [7:0] FLRF_B_PEAK = 8'h17;       // 23,24
   localparam logic [7:0] FLRF_B_RSV25 = 8'h19;
   localparam logic [7:0] FLRF_B_RSV26 = 8'h1A;
   // most recent event page byte numbers
   localparam logic [7:0] FLRF_B_VOUT = 8'h1B;       // 27,28
   localparam logic [7:0] FLRF_B_RSV29 = 8'h1D;
   localparam logic [7:0] FLRF_B_RSV30 = 8'h1E;
   localparam logic [7:0] FLRF_B_IOUT = 8'h1F;       // 31,32
   localparam logic [7:0] FLRF_B_IINC = 8'h21;       // 33,34
   localparam logic [7:0] FLRF_B_VIN = 8'h23;        // 35,36
   localparam logic [7:0] FLRF_B_IIN = 8'h25;        // 37,38
   localparam logic [7:0] FLRF_B_STAT = 8'h27;       // 39
   // adc multiplexer schedule
   localparam logic [4:0] FLRF_STEP_VOUT = 5'h00;
   localparam logic [4:0] FLRF_STEP_IOUT = 5'h01;
   localparam logic [4:0] FLRF_STEP_IINC = 5'h02;
   localparam logic [4:0] FLRF_STEP_VIN = 5'h03;
   localparam logic [4:0] FLRF_STEP_IIN = 5'h04;
   localparam logic [4:0] FLRF_STEP_TEXT = 5'h05;
   localparam logic [4:0] FLRF_STEP_TDIE = 5'h06;
   localparam logic [4:0] FLRF_STEP_LAST = 5'h19;    // step 25
   localparam int FLRF_EVENT_PAGES = 6;
   // lin11 mantissa width and width of the comparable value
   localparam int FLRF_MANT_W = 11;
   localparam int FLRF_CMP_W = 43;
   // readout sequencer
   typedef enum logic [1:0] {
      FLRF_RD_IDLE = 2'b00,
      FLRF_RD_LEN = 2'b01,
      FLRF_RD_DATA = 2'b10
   } flrf_rd_t;
endpackage : flrf_pkg

// >>> core/flrf_buf.sv
// Purpose: two-entry buffer between the record serializer and the host byte port
// Assumes: single clock, reset already synchronised
// Notes: in_ready_out drops only when both entries are full, so no word is lost
`timescale 1ns/1ps
module flrf_buf #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // filling side
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   // draining side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] cnt;
   } flrf_buf_state_t;

   flrf_buf_state_t s_q, s_d;
   logic push, pop;

   // handshakes from occupancy
   assign in_ready_out = (s_q.cnt != 2'h2);
   assign out_valid_out = (s_q.cnt != 2'h0);
   assign out_data_out = s_q.mem[s_q.rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // pointer and count update
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data_in;
         s_d.wr_ptr = ~s_q.wr_ptr;
      end
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + 2'h1;
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - 2'h1;
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : flrf_buf

// >>> core/flrf_formatter.sv
// Purpose: snapshot of the last event and serializer of the fault log record
// Assumes: adc results arrive tagged with their mux step, steps 0..25 per pass
// Notes: bytes outside this block's fields are fetched from other_byte_in
// Function
// - external temperature of last event at bytes 17-18, high byte first.
// - reserved record bytes 19,20,25,26,29,30 return 0x00.
// - die temperature of last event at bytes 21-22, high byte first.
// - track highest external temperature since peak clear; place at bytes 23-24.
// - event page is built from one full mux pass covering the fault.
// - after a fault keep converting to step 25, then request the store.
// - page layout 27-28 vout, 31-38 currents and vin, 39 vout status.
// - block read length 147, or zero when no log was captured.
`timescale 1ns/1ps
module flrf_formatter (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // adc result stream
   input wire logic adc_valid_in,
   input wire logic [4:0] adc_step_in,
   input wire logic [15:0] adc_data_in,
   input wire logic [7:0] vout_status_in,
   // logging control
   input wire logic log_enable_in,
   input wire logic log_trigger_in,
   input wire logic peak_clear_command_in,
   output logic store_req_out,
   output logic log_valid_out,
   // other record bytes
   output logic [7:0] other_idx_out,
   input wire logic [7:0] other_byte_in,
   // fault_record_readout byte stream
   input wire logic rd_start_in,
   output logic rd_busy_out,
   output logic byte_valid_out,
   output logic [7:0] byte_data_out,
   input wire logic byte_ready_in
);
   import flrf_pkg::*;

   typedef struct packed {
      flrf_rd_t rd;
      logic [7:0] idx;
      logic armed;
      logic log_valid;
      logic store;
      logic peak_valid;
      logic [15:0] text;
      logic [15:0] tdie;
      logic [15:0] peak;
      logic [15:0] vout;
      logic [15:0] iout;
      logic [15:0] iinc;
      logic [15:0] vin;
      logic [15:0] iin;
      logic [15:0] c_text;
      logic [15:0] c_tdie;
      logic [15:0] c_peak;
      logic [15:0] c_vout;
      logic [15:0] c_iout;
      logic [15:0] c_iinc;
      logic [15:0] c_vin;
      logic [15:0] c_iin;
      logic [7:0] c_stat;
   } flrf_state_t;

   flrf_state_t s_q, s_d;
   logic [1:0] rst_sync_q;
   logic rst_b;
   logic push_valid, push_ready;
   logic [7:0] push_data;

   // reset release through two flops
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_q[1];

   // lin11 word to a comparable signed value, mantissa shifted by exponent plus 16
   function automatic logic signed [FLRF_CMP_W-1:0] lin11_val(input logic [15:0] w);
      logic signed [FLRF_CMP_W-1:0] m;
      logic [4:0] sh;
      m = {{(FLRF_CMP_W-FLRF_MANT_W){w[FLRF_MANT_W-1]}}, w[FLRF_MANT_W-1:0]};
      sh = {~w[15], w[14:11]};
      return m <<< sh;
   endfunction : lin11_val

   // byte of the stored record at a given byte number
   function automatic logic [7:0] rec_byte(input flrf_state_t s, input logic [7:0] i, input logic [7:0] oth);
      logic [7:0] b;
      b = oth;
      case (i)
         FLRF_B_TEXT: b = s.c_text[15:8];
         FLRF_B_TEXT + 8'h01: b = s.c_text[7:0];
         FLRF_B_RSV19, FLRF_B_RSV20, FLRF_B_RSV25, FLRF_B_RSV26,
         FLRF_B_RSV29, FLRF_B_RSV30: b = FLRF_RSVD_BYTE;
         FLRF_B_TDIE: b = s.c_tdie[15:8];
         FLRF_B_TDIE + 8'h01: b = s.c_tdie[7:0];
         FLRF_B_PEAK: b = s.c_peak[15:8];
         FLRF_B_PEAK + 8'h01: b = s.c_peak[7:0];
         FLRF_B_VOUT: b = s.c_vout[15:8];
         FLRF_B_VOUT + 8'h01: b = s.c_vout[7:0];
         FLRF_B_IOUT: b = s.c_iout[15:8];
         FLRF_B_IOUT + 8'h01: b = s.c_iout[7:0];
         FLRF_B_IINC: b = s.c_iinc[15:8];
         FLRF_B_IINC + 8'h01: b = s.c_iinc[7:0];
         FLRF_B_VIN: b = s.c_vin[15:8];
         FLRF_B_VIN + 8'h01: b = s.c_vin[7:0];
         FLRF_B_IIN: b = s.c_iin[15:8];
         FLRF_B_IIN + 8'h01: b = s.c_iin[7:0];
         FLRF_B_STAT: b = s.c_stat;
         default: b = oth;
      endcase
      return b;
   endfunction : rec_byte

   // serializer output toward the buffer
   assign other_idx_out = s_q.idx;
   assign push_valid = (s_q.rd != FLRF_RD_IDLE);
   assign push_data = (s_q.rd == FLRF_RD_LEN) ? (s_q.log_valid ? FLRF_REC_LEN : FLRF_LEN_NONE)
                                              : rec_byte(s_q, s_q.idx, other_byte_in);
   assign rd_busy_out = (s_q.rd != FLRF_RD_IDLE);
   assign store_req_out = s_q.store;
   assign log_valid_out = s_q.log_valid;

   // live values, peak tracking, snapshot and readout sequencing
   always_comb begin
      s_d = s_q;
      s_d.store = 1'b0;
      // latest reading of each quantity in the running pass
      if (adc_valid_in) begin
         case (adc_step_in)
            FLRF_STEP_VOUT: s_d.vout = adc_data_in;
            FLRF_STEP_IOUT: s_d.iout = adc_data_in;
            FLRF_STEP_IINC: s_d.iinc = adc_data_in;
            FLRF_STEP_VIN: s_d.vin = adc_data_in;
            FLRF_STEP_IIN: s_d.iin = adc_data_in;
            FLRF_STEP_TEXT: s_d.text = adc_data_in;
            FLRF_STEP_TDIE: s_d.tdie = adc_data_in;
            default: s_d.vout = s_d.vout;
         endcase
      end
      // peak of external temperature; first reading after a clear seeds it
      if (peak_clear_command_in) begin
         s_d.peak_valid = 1'b0;
      end else if (adc_valid_in && adc_step_in == FLRF_STEP_TEXT) begin
         if (!s_q.peak_valid || lin11_val(adc_data_in) > lin11_val(s_q.peak)) begin
            s_d.peak = adc_data_in;
         end
         s_d.peak_valid = 1'b1;
      end
      // arm on an enabled trigger, snapshot when the pass reaches its last step
      if (log_trigger_in && log_enable_in) begin
         s_d.armed = 1'b1;
      end
      if (s_q.armed && adc_valid_in && adc_step_in == FLRF_STEP_LAST && s_q.rd == FLRF_RD_IDLE) begin
         s_d.armed = 1'b0;
         s_d.store = 1'b1;
         s_d.log_valid = 1'b1;
         s_d.c_text = s_d.text;
         s_d.c_tdie = s_d.tdie;
         s_d.c_peak = s_d.peak;
         s_d.c_vout = s_d.vout;
         s_d.c_iout = s_d.iout;
         s_d.c_iinc = s_d.iinc;
         s_d.c_vin = s_d.vin;
         s_d.c_iin = s_d.iin;
         s_d.c_stat = vout_status_in;
      end
      // readout: length byte then, when a log is held, bytes 0..146 in ascending order
      case (s_q.rd)
         FLRF_RD_IDLE: begin
            if (rd_start_in) begin
               s_d.rd = FLRF_RD_LEN;
               s_d.idx = 8'h00;
            end
         end
         FLRF_RD_LEN: begin
            if (push_ready) begin
               s_d.rd = s_q.log_valid ? FLRF_RD_DATA : FLRF_RD_IDLE;
            end
         end
         FLRF_RD_DATA: begin
            if (push_ready) begin
               if (s_q.idx == FLRF_LAST_IDX) begin
                  s_d.rd = FLRF_RD_IDLE;
                  s_d.idx = 8'h00;
               end else begin
                  s_d.idx = s_q.idx + 8'h01;
               end
            end
         end
         default: s_d.rd = FLRF_RD_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // two-entry buffer toward the host
   flrf_buf #(
      .W(8)
   ) u_buf (
      .clk_in(clk_in),
      .rst_b_in(rst_b),
      .in_valid_in(push_valid),
      .in_data_in(push_data),
      .in_ready_out(push_ready),
      .out_valid_out(byte_valid_out),
      .out_data_out(byte_data_out),
      .out_ready_in(byte_ready_in)
   );
endmodule : flrf_formatter

// >>> tb/flrf_host.sv
// Purpose: host side of the record byte stream, collecting every byte it accepts
// Assumes: ready changes only on the falling edge
// Notes: slow_in makes the host stall every other cycle
`timescale 1ns/1ps
module flrf_host (
   // clock and control
   input wire logic clk_in,
   input wire logic slow_in,
   // byte stream
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_data_in,
   output logic byte_ready_out
);
   logic ph = 1'b0;
   logic [7:0] got[$];
   initial byte_ready_out = 1'b0;
   // ready pattern, stalling on alternate cycles when slow
   always @(negedge clk_in) begin
      ph <= ~ph;
      byte_ready_out <= !slow_in || ph;
   end
   // take a byte on each accepting edge
   always @(posedge clk_in) begin
      if (byte_valid_in && byte_ready_out) got.push_back(byte_data_in);
   end
endmodule : flrf_host

// >>> tb/flrf_formatter_sva.sv
// Purpose: port-level checks of the fault log record formatter
// Assumes: one clock, asynchronous active-low reset
// Notes: bound into every formatter instance
`timescale 1ns/1ps
module flrf_formatter_sva (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // watched ports
   input wire logic adc_valid_in,
   input wire logic [4:0] adc_step_in,
   input wire logic rd_start_in,
   input wire logic store_req_out,
   input wire logic log_valid_out,
   input wire logic [7:0] other_idx_out,
   input wire logic rd_busy_out,
   input wire logic byte_valid_out,
   input wire logic [7:0] byte_data_out,
   input wire logic byte_ready_in
);
   import flrf_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // properties
   property p_len;
      rd_start_in && !rd_busy_out && !byte_valid_out |->
         ##2 byte_valid_out && byte_data_out == (log_valid_out ? FLRF_REC_LEN : FLRF_LEN_NONE);
   endproperty
   property p_store_pulse;
      store_req_out |=> !store_req_out;
   endproperty
   property p_store_valid;
      store_req_out |-> log_valid_out;
   endproperty
   property p_valid_stays;
      log_valid_out |=> log_valid_out;
   endproperty
   property p_hold;
      byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_data_out);
   endproperty
   property p_store_step;
      $rose(store_req_out) |-> $past(adc_valid_in && adc_step_in == FLRF_STEP_LAST);
   endproperty
   property p_ascend;
      rd_busy_out && $past(rd_busy_out) && $changed(other_idx_out) |->
         other_idx_out == $past(other_idx_out) + 8'h01;
   endproperty
   // an empty log ends the read right after the length byte
   property p_busy;
      rd_start_in && !rd_busy_out && !byte_valid_out |=> rd_busy_out ##1 (rd_busy_out == log_valid_out);
   endproperty
   a_len: assert property (p_len) else $error("length byte wrong");
   a_store_pulse: assert property (p_store_pulse) else $error("store request too long");
   a_store_valid: assert property (p_store_valid) else $error("log not flagged");
   a_valid_stays: assert property (p_valid_stays) else $error("log flag dropped");
   a_hold: assert property (p_hold) else $error("byte lost under stall");
   a_store_step: assert property (p_store_step) else $error("store before last step");
   a_ascend: assert property (p_ascend) else $error("byte order broken");
   a_busy: assert property (p_busy) else $error("read not started");
   // main scenarios
   c_store: cover property (store_req_out);
   c_read: cover property (rd_start_in && !rd_busy_out);
   c_stall: cover property (byte_valid_out && !byte_ready_in);
endmodule : flrf_formatter_sva
bind flrf_formatter flrf_formatter_sva chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .adc_valid_in(adc_valid_in),
   .adc_step_in(adc_step_in), .rd_start_in(rd_start_in), .store_req_out(store_req_out),
   .log_valid_out(log_valid_out), .other_idx_out(other_idx_out), .rd_busy_out(rd_busy_out),
   .byte_valid_out(byte_valid_out), .byte_data_out(byte_data_out), .byte_ready_in(byte_ready_in));

// >>> tb/flrf_formatter_tb.sv
// Purpose: self-checking bench of the fault log record formatter
// Assumes: inputs change on the falling edge
// Notes: bytes not owned by the block come from idx xor A5
`timescale 1ns/1ps
module flrf_formatter_tb;
   import flrf_pkg::*;
   logic clk_in, rst_b_in, adc_valid_in, log_enable_in, log_trigger_in, peak_clear_command_in;
   logic rd_start_in, slow, store_req_out, log_valid_out, rd_busy_out, byte_valid_out, byte_ready_in;
   logic [4:0] adc_step_in;
   logic [15:0] adc_data_in;
   logic [7:0] vout_status_in, other_byte_in, other_idx_out, byte_data_out;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int n_store = 0;
   // bytes supplied from outside the block
   assign other_byte_in = other_idx_out ^ 8'hA5;
   flrf_formatter uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .adc_valid_in(adc_valid_in),
      .adc_step_in(adc_step_in), .adc_data_in(adc_data_in), .vout_status_in(vout_status_in),
      .log_enable_in(log_enable_in), .log_trigger_in(log_trigger_in),
      .peak_clear_command_in(peak_clear_command_in), .store_req_out(store_req_out),
      .log_valid_out(log_valid_out), .other_idx_out(other_idx_out), .other_byte_in(other_byte_in),
      .rd_start_in(rd_start_in), .rd_busy_out(rd_busy_out), .byte_valid_out(byte_valid_out),
      .byte_data_out(byte_data_out), .byte_ready_in(byte_ready_in));
   flrf_host host (.clk_in(clk_in), .slow_in(slow), .byte_valid_in(byte_valid_out),
      .byte_data_in(byte_data_out), .byte_ready_out(byte_ready_in));
   // clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // store pulse count and hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (store_req_out === 1'b1) n_store++;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task give_verdict;
      if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // stimulus word of a measurement step
   function automatic logic [15:0] step_word(input int s);
      return 16'(16'h1234 + 16'hBEDD * s);
   endfunction : step_word
   task adc(input int s, input logic [15:0] t, input logic trg);
      @(negedge clk_in);
      adc_valid_in = 1'b1;
      adc_step_in = s[4:0];
      adc_data_in = (s == 5) ? t : (s < 7) ? step_word(s) : 16'h0F0F; // ext temp from t, others fixed
      log_trigger_in = trg;
      @(negedge clk_in);
      adc_valid_in = 1'b0;
      log_trigger_in = 1'b0;
   endtask : adc
   task pass(input int trg, input logic [15:0] t);
      for (int s = 0; s < 26; s++) adc(s, t, s == trg);
      @(negedge clk_in);
   endtask : pass
   // expected record byte; odd byte numbers carry the high byte of a word
   function automatic logic [15:0] exp_byte(input int i);
      logic [15:0] w;
      w = 16'h0000;
      case (i)
         17, 18: w = 16'hE064;
         21, 22: w = step_word(6);
         23, 24: w = 16'hE0C8;
         27, 28, 31, 32, 33, 34, 35, 36, 37, 38: w = step_word((i > 30) ? (i - 29) / 2 : 0);
         19, 20, 25, 26, 29, 30: return 16'h0000;
         39: return 16'h005A;
         default: return {8'h00, 8'(i) ^ 8'hA5};
      endcase
      return {8'h00, (i % 2) ? w[15:8] : w[7:0]};
   endfunction : exp_byte
   task rd(input logic sl);
      int k;
      host.got.delete();
      slow = sl;
      @(negedge clk_in);
      rd_start_in = 1'b1;
      @(negedge clk_in);
      rd_start_in = 1'b0;
      k = 0;
      while ((rd_busy_out !== 1'b0 || byte_valid_out !== 1'b0) && k < 2000) begin
         @(negedge clk_in);
         k++;
      end
   endtask : rd
   task t_empty;
      rd(1'b0);
      chk("count", 16'd1, 16'(host.got.size()));
      chk("length", FLRF_LEN_NONE, host.got[0]);
   endtask : t_empty
   task t_capture;
      pass(30, 16'hE1F0); // high reading that the clear must forget
      @(negedge clk_in);
      peak_clear_command_in = 1'b1;
      @(negedge clk_in);
      peak_clear_command_in = 1'b0;
      pass(10, 16'hE0C8);
      chk("store off", 16'd0, 16'(n_store));
      log_enable_in = 1'b1;
      pass(15, 16'hE064);
      chk("store", 16'd1, 16'(n_store));
      chk("logged", 16'd1, {15'd0, log_valid_out});
   endtask : t_capture
   task t_read;
      for (int sl = 0; sl < 2; sl++) begin
         rd(sl[0]);
         chk("count", 16'd148, 16'(host.got.size()));
         chk("length", FLRF_REC_LEN, host.got[0]);
         for (int i = 0; i < 147; i++) chk($sformatf("byte %0d", i), exp_byte(i), host.got[i + 1]);
      end
   endtask : t_read
   // main sequence
   initial begin
      {rst_b_in, adc_valid_in, log_enable_in, log_trigger_in, peak_clear_command_in, rd_start_in, slow} = '0;
      adc_step_in = 5'h00;
      adc_data_in = 16'h0000;
      vout_status_in = 8'h5A;
      repeat (5) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (3) @(negedge clk_in);
      t_empty();
      t_capture();
      t_read();
      give_verdict();
   end
endmodule : flrf_formatter_tb
